//--- spie_consts.vh
`ifndef SPIE_CONSTS_VH
`define SPIE_CONSTS_VH

// ==========================================================================
// bus geometry
`define SPIE_ADDR_W       8
`define SPIE_DATA_W       8
`define SPIE_SA6_W        4
`define SPIE_EV_W         5

// ==========================================================================
// register offsets
`define SPIE_OFS_STATUS   8'h0C
`define SPIE_OFS_ENABLE   8'h0D
`define SPIE_OFS_STATE    8'h0E

// ==========================================================================
// reset values
`define SPIE_EN_RESET     5'h00
`define SPIE_STAT_RESET   5'h00
`define SPIE_SA6_RESET    4'h0
`define SPIE_RD_RESET     8'h00

// ==========================================================================
// bit positions shared by status and enable
`define SPIE_BIT_0000     0
`define SPIE_BIT_OTHER    1
`define SPIE_BIT_001X     2
`define SPIE_BIT_1000     3
`define SPIE_BIT_1010     4

// ==========================================================================
// sa6 patterns and compare masks
`define SPIE_PAT_1111     4'hF
`define SPIE_PAT_1110     4'hE
`define SPIE_PAT_1100     4'hC
`define SPIE_PAT_1010     4'hA
`define SPIE_PAT_1000     4'h8
`define SPIE_PAT_001X     4'h2
`define SPIE_PAT_0000     4'h0
`define SPIE_CARE_ALL     4'hF
`define SPIE_CARE_001X    4'hE

`endif

//--- spie_change_det.v
`include "spie_consts.vh"

// ==========================================================================
// pattern match with entry/exit detection
module spie_change_det #(
  parameter [3:0] PATTERN = `SPIE_PAT_0000,
  parameter [3:0] CARE    = `SPIE_CARE_ALL
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] sa6_value,
  input  wire       primed,
  output wire       match,
  output wire       change
);

  reg match_reg;

  // masked compare; a zero in CARE drops that bit from the test
  assign match = ((sa6_value ^ PATTERN) & CARE) == 4'h0;

  // previous match state, so both entry and exit give an event
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= match;
    end
  end

  // no event until a reference sample has been taken
  assign change = primed & (match ^ match_reg);

endmodule

//--- spie_sticky.v
`include "spie_consts.vh"

// ==========================================================================
// sticky event bits, cleared on read or by writing ones
module spie_sticky #(
  parameter W = `SPIE_EV_W
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] set_vec,
  input  wire         rd_clear,
  input  wire [W-1:0] wr_clear,
  output wire [W-1:0] status
);

  reg  [W-1:0] status_reg;
  wire [W-1:0] clr_mask;
  wire [W-1:0] status_next;

  // a read clears every bit, a write only the bits written as one
  assign clr_mask    = rd_clear ? {W{1'b1}} : wr_clear;
  // set is applied after clear, so a same-cycle event is kept
  assign status_next = (status_reg & ~clr_mask) | set_vec;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= {W{1'b0}};
    end else begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;

endmodule

//--- spie_sa6_irq.v
// Behaviour
// - bit 4 enables 1010 entry/exit interrupts
// - bit 3 enables 1000 entry/exit interrupts
// - bit 2 enables 001x entry/exit, lsb ignored
// - bit 0 enables 0000 entry/exit interrupts
// - enables read/write, one permits, reset zero
// - events latch sticky, cleared on read
`include "spie_consts.vh"

// ==========================================================================
// sa6 pattern change interrupt logic, one channel
module spie_sa6_irq #(
  parameter SA6_W = `SPIE_SA6_W,
  parameter EV_W  = `SPIE_EV_W
) (
  input  wire                    clk,
  input  wire                    rst,
  input  wire [SA6_W-1:0]        sa6_debounced,
  input  wire [`SPIE_ADDR_W-1:0] reg_addr,
  input  wire [`SPIE_DATA_W-1:0] reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output wire [`SPIE_DATA_W-1:0] reg_rdata,
  output wire                    irq
);

  // ========================================================================
  // pattern table
  // the upper three patterns only serve to exclude values from the
  // unlisted class; their own interrupts live elsewhere
  localparam NPAT = 7;
  localparam [4*NPAT-1:0] PATS = {
    `SPIE_PAT_1111, `SPIE_PAT_1110, `SPIE_PAT_1100,
    `SPIE_PAT_1010, `SPIE_PAT_1000, `SPIE_PAT_001X,
    `SPIE_PAT_0000
  };
  localparam [4*NPAT-1:0] CARES = {
    `SPIE_CARE_ALL, `SPIE_CARE_ALL, `SPIE_CARE_ALL,
    `SPIE_CARE_ALL, `SPIE_CARE_ALL, `SPIE_CARE_001X,
    `SPIE_CARE_ALL
  };
  // table slots of the four patterns that raise interrupts here
  localparam SLOT_0000 = 0;
  localparam SLOT_001X = 1;
  localparam SLOT_1000 = 2;
  localparam SLOT_1010 = 3;

  localparam DW = `SPIE_DATA_W;

  // ========================================================================
  // declarations
  reg  [EV_W-1:0]  enable_reg;
  reg  [EV_W-1:0]  enable_next;
  reg  [SA6_W-1:0] sa6_prev_reg;
  reg              primed_reg;
  reg  [DW-1:0]    rdata_reg;
  reg  [DW-1:0]    rdata_next;

  wire [NPAT-1:0]  pat_match;
  wire [NPAT-1:0]  pat_change;
  wire             other_now;
  wire             value_moved;
  wire             other_event;
  wire [EV_W-1:0]  event_vec;
  wire [EV_W-1:0]  status;
  wire [EV_W-1:0]  pending;

  wire             hit_status;
  wire             hit_enable;
  wire             hit_state;
  wire             status_rd;
  wire [EV_W-1:0]  status_w1c;

  // ========================================================================
  // address decode
  assign hit_status = reg_addr == `SPIE_OFS_STATUS;
  assign hit_enable = reg_addr == `SPIE_OFS_ENABLE;
  assign hit_state  = reg_addr == `SPIE_OFS_STATE;

  // the read of the status word is what clears it
  assign status_rd  = reg_rd & hit_status;
  assign status_w1c = (reg_wr & hit_status) ? reg_wdata[EV_W-1:0]
                                            : {EV_W{1'b0}};

  // ========================================================================
  // enable register
  // upper bits of the byte are not kept here and read back as zero
  always @* begin
    enable_next = enable_reg;
    if (reg_wr && hit_enable) begin
      enable_next = reg_wdata[EV_W-1:0];
    end
  end

  // all enables off after reset so nothing fires before setup
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= `SPIE_EN_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // ========================================================================
  // reference sample
  // the first cycle after reset only captures the sa6 value; without
  // this a line already at 0000 would look like an entry event
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      primed_reg   <= 1'b0;
      sa6_prev_reg <= `SPIE_SA6_RESET;
    end else begin
      primed_reg   <= 1'b1;
      sa6_prev_reg <= sa6_debounced;
    end
  end

  // ========================================================================
  // pattern detectors, one per table entry
  genvar gi;
  generate
    for (gi = 0; gi < NPAT; gi = gi + 1) begin : g_pat
      spie_change_det #(
        .PATTERN (PATS[4*gi +: 4]),
        .CARE    (CARES[4*gi +: 4])
      ) u_det (
        .clk       (clk),
        .rst       (rst),
        .sa6_value (sa6_debounced),
        .primed    (primed_reg),
        .match     (pat_match[gi]),
        .change    (pat_change[gi])
      );
    end
  endgenerate

  // ========================================================================
  // unlisted values
  // fires each time the value moves to a new unlisted value, so a walk
  // between two unlisted values still reports; leaving the class is
  // seen through the entry event of the listed pattern reached when that is 1010, 1000, 001x or 0000; 1111, 1110 and 1100 give none here
  assign other_now   = ~|pat_match;
  assign value_moved = primed_reg & (sa6_debounced != sa6_prev_reg);
  assign other_event = value_moved & other_now;

  // ========================================================================
  // event vector in status/enable layout
  assign event_vec[`SPIE_BIT_1010]  = pat_change[SLOT_1010];
  assign event_vec[`SPIE_BIT_1000]  = pat_change[SLOT_1000];
  assign event_vec[`SPIE_BIT_001X]  = pat_change[SLOT_001X];
  assign event_vec[`SPIE_BIT_OTHER] = other_event;
  assign event_vec[`SPIE_BIT_0000]  = pat_change[SLOT_0000];

  // ========================================================================
  // sticky status
  // events latch whatever the enables say, so software can poll them
  spie_sticky #(
    .W (EV_W)
  ) u_status (
    .clk      (clk),
    .rst      (rst),
    .set_vec  (event_vec),
    .rd_clear (status_rd),
    .wr_clear (status_w1c),
    .status   (status)
  );

  // ========================================================================
  // interrupt output
  // level output built from flops only, no glitch from the bus side
  assign pending = status & enable_reg;
  assign irq     = |pending;

  // ========================================================================
  // read data, valid the cycle after the strobe
  // the status word is captured before the clear takes effect, so the
  // read reports exactly what is then discarded
  always @* begin
    rdata_next = {DW{1'b0}};
    if (reg_rd) begin
      if (hit_status) begin
        rdata_next[EV_W-1:0] = status;
      end else if (hit_enable) begin
        rdata_next[EV_W-1:0] = enable_reg;
      end else if (hit_state) begin
        rdata_next[SA6_W-1:0] = sa6_prev_reg;
      end
    end
  end

  // unmapped reads and idle cycles return zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `SPIE_RD_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

//--- spie_sa6_irq_chk.sv
`include "spie_consts.vh"
// ==========================================================================
// shadow enable and status, checked against the register port and irq
module spie_sa6_irq_chk (
  input wire       clk,
  input wire       rst,
  input wire [3:0] sa6_debounced,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [3:0] prv_reg;
  reg        primed_reg;
  reg  [4:0] en_reg;
  reg  [4:0] st_reg;
  // event decode; first edge after reset only takes a reference
  wire [3:0] v     = sa6_debounced;
  wire       en_wr = reg_wr && reg_addr == `SPIE_OFS_ENABLE;
  wire       en_rd = reg_rd && reg_addr == `SPIE_OFS_ENABLE;
  wire       st_rd = reg_rd && reg_addr == `SPIE_OFS_STATUS;
  wire       st_wr = reg_wr && reg_addr == `SPIE_OFS_STATUS;
  wire       lst   = v inside {4'hF, 4'hE, 4'hC, 4'hA, 4'h8, 4'h2, 4'h3, 4'h0};
  wire [4:0] ev    = {5{primed_reg}} & {(v == 4'hA) != (prv_reg == 4'hA),
    (v == 4'h8) != (prv_reg == 4'h8), (v[3:1] == 3'h1) != (prv_reg[3:1] == 3'h1),
    !lst && v != prv_reg, (v == 4'h0) != (prv_reg == 4'h0)};
  // a write to enable in the same cycle may withdraw the permission
  wire [4:0] hit   = ev & en_reg & {5{!en_wr}};
  // shadow state; an event beats a clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prv_reg <= 4'h0;
      primed_reg <= 1'b0;
      en_reg <= 5'h00;
      st_reg <= 5'h00;
    end else begin
      prv_reg <= v;
      primed_reg <= 1'b1;
      if (en_wr) en_reg <= reg_wdata[4:0];
      st_reg <= (st_rd ? 5'h00 : st_wr ? st_reg & ~reg_wdata[4:0] : st_reg) | ev;
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ev_1010; hit[4] |=> irq; endproperty
  a_ev_1010: assert property (p_ev_1010)
    else $error("1010 change gave no irq");
  property p_ev_1000; hit[3] |=> irq; endproperty
  a_ev_1000: assert property (p_ev_1000)
    else $error("1000 change gave no irq");
  property p_ev_001x; hit[2] |=> irq; endproperty
  a_ev_001x: assert property (p_ev_001x)
    else $error("001x change gave no irq");
  property p_ev_other; hit[1] |=> irq; endproperty
  a_ev_other: assert property (p_ev_other)
    else $error("unlisted value gave no irq");
  property p_ev_0000; hit[0] |=> irq; endproperty
  a_ev_0000: assert property (p_ev_0000)
    else $error("0000 change gave no irq");
  property p_en_read; en_rd |=> reg_rdata == {3'h0, $past(en_reg)}; endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable readback wrong");
  property p_st_read; st_rd |=> reg_rdata == {3'h0, $past(st_reg)}; endproperty
  a_st_read: assert property (p_st_read)
    else $error("status readback wrong");
  property p_irq_lvl; irq == |(st_reg & en_reg); endproperty
  a_irq_lvl: assert property (p_irq_lvl)
    else $error("irq level differs from status and enable");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  c_irq: cover property ($rose(irq));
  c_clr: cover property (st_rd && st_reg != 5'h00);
  c_other: cover property (ev[1]);
endmodule

//--- test_spie_sa6_irq.sv
`include "spie_consts.vh"
// ==========================================================================
// bench: driver notes expected read data, monitor compares
module test_spie_sa6_irq;
  timeunit 1ns;
  timeprecision 1ps;
  reg        clk, rst, wr, rd, rd_d;
  reg  [3:0] sa6, prev, v;
  reg  [7:0] addr, wdata;
  wire [7:0] rdata;
  wire       irq;
  reg  [7:0] exp_q[$];
  integer    err_count = 0, n_compared = 0, seed = 32'hD01FAF47, i;
  spie_sa6_irq u_spie_sa6_irq (.clk(clk), .rst(rst), .sa6_debounced(sa6),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq(irq));
  // expected events from previous and new value
  function [4:0] ev(input [3:0] p, input [3:0] n);
    ev = {(n == 4'hA) != (p == 4'hA), (n == 4'h8) != (p == 4'h8),
      (n[3:1] == 3'h1) != (p[3:1] == 3'h1), n != p &&
      !(n inside {4'hF, 4'hE, 4'hC, 4'hA, 4'h8, 4'h2, 4'h3, 4'h0}),
      (n == 4'h0) != (p == 4'h0)};
  endfunction
  task chk(input [7:0] got, input [7:0] want);
    n_compared++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // one edge of stimulus; every input but rst assigned once per edge
  task step(input [3:0] s, input w, input r, input [7:0] a, d, e);
    @(posedge clk);
    sa6 <= s;
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r) exp_q.push_back(e);
  endtask
  // settle one new value, then read status; x adds bits already latched
  task pat(input [3:0] s, input [4:0] x);
    step(s, 0, 0, 8'h00, 8'h00, 8'h00);
    step(s, 0, 1, 8'h0C, 8'h00, {3'h0, ev(prev, s) | x});
    prev = s;
  endtask
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // monitor: read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(rdata, exp_q.pop_front());
    rd_d <= rd;
  end
  initial begin
    {rst, wr, rd, rd_d, sa6, prev, addr, wdata} = 28'h8000000; // rst only
    repeat (8) @(posedge clk);
    rst <= 0;
    step(0, 0, 1, 8'h0D, 8'h00, 8'h00);
    step(0, 0, 1, 8'h0C, 8'h00, 8'h00);
    step(0, 1, 0, 8'h0D, 8'hFF, 8'h00);
    step(0, 0, 1, 8'h0D, 8'h00, 8'h1F);
    step(0, 1, 0, 8'h55, 8'hFF, 8'h00);
    step(0, 0, 1, 8'h55, 8'h00, 8'h00);
    $display("register test done");
    // corner values first (001x pairing, leaving unlisted), then random
    for (i = 0; i < 60; i++) begin
      v = i < 9 ? 36'h0F095238A >> (i * 4) : 4'($random(seed));
      pat(v, 5'h00);
    end
    $display("pattern test done");
    // masked event latches silently, enabling exposes it, W1C drops it
    pat(0, 5'h00);
    step(0, 1, 0, 8'h0D, 8'h00, 8'h00);
    step(4'hA, 0, 0, 8'h00, 8'h00, 8'h00);
    step(4'hA, 1, 0, 8'h0D, 8'h10, 8'h00);
    #1 chk({7'h0, irq}, 8'h00);
    step(4'hA, 1, 0, 8'h0C, 8'h10, 8'h00);
    #1 chk({7'h0, irq}, 8'h01);
    step(4'hA, 0, 0, 8'h00, 8'h00, 8'h00);
    #1 chk({7'h0, irq}, 8'h00);
    prev = 4'hA;
    step(5, 0, 1, 8'h0C, 8'h00, 8'h01);
    pat(5, 5'h12);
    // let the pending read answer before reset wipes its data
    step(5, 0, 0, 8'h00, 8'h00, 8'h00);
    step(5, 0, 0, 8'h00, 8'h00, 8'h00);
    rst <= 1;
    step(5, 0, 0, 8'h00, 8'h00, 8'h00);
    rst <= 0;
    step(5, 0, 1, 8'h0D, 8'h00, 8'h00);
    step(5, 0, 1, 8'h0C, 8'h00, 8'h00);
    step(5, 0, 1, 8'h0E, 8'h00, 8'h05);
    step(5, 0, 0, 8'h00, 8'h00, 8'h00);
    for (i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk);
    if (exp_q.size() > 0) begin
      err_count++;
      $display("unexpected at %0t: reads left unanswered", $time);
    end
    $display("mask test done");
    test_done;
  end
endmodule
bind spie_sa6_irq spie_sa6_irq_chk u_spie_sa6_irq_chk (.clk(clk), .rst(rst),
  .sa6_debounced(sa6_debounced), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
